// [pnce_pkg.sv]
// Package for the parallel NOR command engine host controller.
// Assumes a 100 MHz system clock and an asynchronous x16 NOR part on the pins.
package pnce_pkg;
  localparam int          ADDR_W        = 19;
  localparam int          DATA_W        = 16;
  localparam int          CLK_NS        = 10;
  // Strobe timing, in ns, then in cycles (least times round up)
  localparam int          STROBE_LOW_NS = 40;
  localparam int          STROBE_LOW_CY = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SETUP_NS      = 20;
  localparam int          SETUP_CY      = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          READ_NS       = 70;
  localparam int          READ_CY       = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int          GLITCH_NS     = 5;
  localparam int          GLITCH_CY     = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SETTLE_US     = 1;
  localparam int          SETTLE_CY     = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int          PROG_US       = 20;
  localparam int          PROG_CY       = (PROG_US * 1000) / CLK_NS;
  localparam int          CNT_W         = 16;
  // Command codes and unlock addresses
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 19'h05555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 19'h02aaa;
  localparam logic [7:0]  CODE_UNLOCK1  = 8'haa;
  localparam logic [7:0]  CODE_UNLOCK2  = 8'h55;
  localparam logic [7:0]  CODE_PROGRAM  = 8'ha0;
  localparam logic [7:0]  CODE_ERASE    = 8'h80;
  localparam logic [7:0]  CODE_SECTOR   = 8'h30;
  localparam logic [7:0]  CODE_BLOCK    = 8'h50;
  localparam logic [7:0]  CODE_CHIP     = 8'h10;
  localparam int          SECTOR_LSB    = 11;
  localparam int          BLOCK_LSB     = 15;
  localparam int          POLL_BIT      = 7;
  localparam int          TOGGLE_BIT    = 6;
  localparam int          MAX_STEPS     = 6;
  typedef enum logic [2:0]
  {
    OP_READ    = 3'b000,
    OP_PROGRAM = 3'b001,
    OP_SECTOR  = 3'b010,
    OP_BLOCK   = 3'b011,
    OP_CHIP    = 3'b100
  } pnce_op_t;
endpackage : pnce_pkg

// [pnce_cycle_if.sv]
// Bundle between the sequencer and the bus cycle engine.
// Assumes both sides share clk.
`timescale 1ns/100ps
interface pnce_cycle_if;
  import pnce_pkg::*;
  logic              req;
  logic              isWrite;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport seq (output req, isWrite, addr, wdata, input done, rdata);
  modport eng (input req, isWrite, addr, wdata, output done, rdata);
endinterface : pnce_cycle_if

// [pnce_bus_cycle.sv]
// One asynchronous flash bus cycle, read or write, paced in clk cycles.
// Assumes the requester holds req until done pulses.
`timescale 1ns/100ps
module pnce_bus_cycle
  import pnce_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  pnce_cycle_if.eng                cyc,
  input  wire logic [DATA_W-1:0]   flashDqIn,
  output logic                     chipSelect_n,
  output logic                     outputGate_n,
  output logic                     writeStrobe_n,
  output logic [ADDR_W-1:0]        flashAddr,
  output logic [DATA_W-1:0]        flashDqOut,
  output logic                     flashDqOe
);
  typedef enum logic [1:0]
  {
    CY_IDLE  = 2'b00,
    CY_SETUP = 2'b01,
    CY_PULSE = 2'b10,
    CY_DONE  = 2'b11
  } pnce_cy_t;
  pnce_cy_t         state_r;
  logic [CNT_W-1:0] cnt_r;
  logic             wr_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r       <= CY_IDLE;
      cnt_r         <= '0;
      wr_r          <= 1'b0;
      chipSelect_n  <= 1'b1;
      outputGate_n  <= 1'b1;
      writeStrobe_n <= 1'b1;
      flashAddr     <= '0;
      flashDqOut    <= '0;
      flashDqOe     <= 1'b0;
      cyc.done      <= 1'b0;
      cyc.rdata     <= '0;
    end
    else
    begin
      cyc.done <= 1'b0;
      case (state_r)
        CY_IDLE:
        begin
          if (cyc.req)
          begin
            // Address is set up before the strobe; it is taken on the last falling edge
            flashAddr    <= cyc.addr;
            flashDqOut   <= cyc.wdata;
            flashDqOe    <= cyc.isWrite;
            wr_r         <= cyc.isWrite;
            chipSelect_n <= 1'b0;
            outputGate_n <= 1'b1;
            cnt_r        <= CNT_W'(SETUP_CY);
            state_r      <= CY_SETUP;
          end
        end
        CY_SETUP:
        begin
          if (cnt_r > CNT_W'(1))
            cnt_r <= cnt_r - CNT_W'(1);
          else
          begin
            // Write strobe low while select is low, far above the glitch floor
            if (wr_r)
            begin
              writeStrobe_n <= 1'b0;
              cnt_r         <= CNT_W'(STROBE_LOW_CY + GLITCH_CY);
            end
            else
            begin
              outputGate_n <= 1'b0;
              cnt_r        <= CNT_W'(READ_CY);
            end
            state_r <= CY_PULSE;
          end
        end
        CY_PULSE:
        begin
          if (cnt_r > CNT_W'(1))
            cnt_r <= cnt_r - CNT_W'(1);
          else
          begin
            // Strobe rises first so data is taken while still driven
            cyc.rdata     <= flashDqIn;
            writeStrobe_n <= 1'b1;
            outputGate_n  <= 1'b1;
            // Done leads the select release, so a held req is gone before idle
            cyc.done      <= 1'b1;
            state_r       <= CY_DONE;
          end
        end
        default:
        begin
          chipSelect_n <= 1'b1;
          flashDqOe    <= 1'b0;
          state_r      <= CY_IDLE;
        end
      endcase
    end
  end
endmodule : pnce_bus_cycle

// [pnce_host.sv]
// Host controller that programs and erases an async x16 NOR flash over its pins.
// Assumes synchronous inputs; cmdStart is honoured only while cmdReady is high.
//
// Overview of operation
// - Host writes with write strobe low, select low
// - Host erases sector before programming its words; OP_PROGRAM does not erase, the caller issues OP_SECTOR first
// - Program: three unlock cycles then address/data
// - Sector 30H, block 50H in sixth cycle
// - Chip erase: 10H at 5555H sixth cycle
// - Inconsistent status: reread twice, both must pass
`timescale 1ns/100ps
module pnce_host
  import pnce_pkg::*;
#(
  parameter int PROG_TIMEOUT_CY = PROG_CY
)
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                cmdStart,
  input  wire logic [2:0]          cmdOp,
  input  wire logic [ADDR_W-1:0]   cmdAddr,
  input  wire logic [DATA_W-1:0]   cmdData,
  output logic                     cmdReady,
  output logic                     cmdDone,
  output logic                     cmdError,
  output logic [DATA_W-1:0]        readData,
  input  wire logic [DATA_W-1:0]   flashDqIn,
  output logic [DATA_W-1:0]        flashDqOut,
  output logic                     flashDqOe,
  output logic [ADDR_W-1:0]        flashAddr,
  output logic                     chipSelect_n,
  output logic                     outputGate_n,
  output logic                     writeStrobe_n
);
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_WRITE = 3'b001,
    ST_POLL  = 3'b010,
    ST_CHECK = 3'b011,
    ST_WAIT  = 3'b100,
    ST_READ  = 3'b101,
    ST_END   = 3'b110
  } pnce_st_t;

  pnce_cycle_if cyc ();

  pnce_st_t          state_r;
  pnce_op_t          op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [2:0]        step_r;
  logic [DATA_W-1:0] prevStatus_r;
  logic [1:0]        reread_r;
  logic [CNT_W-1:0]  wait_r;
  logic [31:0]       busy_r;
  logic              firstPoll_r;
  logic [ADDR_W-1:0] stepAddr;
  logic [DATA_W-1:0] stepData;
  logic [2:0]        lastStep;

  // Erase address aligned to its granule
  function automatic logic [ADDR_W-1:0] alignAddr(input logic [ADDR_W-1:0] a, input int lsb);
    alignAddr = (a >> lsb) << lsb;
  endfunction : alignAddr

  function automatic logic [DATA_W-1:0] cmdWord(input logic [7:0] code);
    cmdWord = {8'h00, code};
  endfunction : cmdWord

  pnce_bus_cycle u_cycle
  (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .cyc           (cyc),
    .flashDqIn     (flashDqIn),
    .chipSelect_n  (chipSelect_n),
    .outputGate_n  (outputGate_n),
    .writeStrobe_n (writeStrobe_n),
    .flashAddr     (flashAddr),
    .flashDqOut    (flashDqOut),
    .flashDqOe     (flashDqOe)
  );

  // Sequence table; protection is permanent so every change is unlocked
  always_comb
  begin
    lastStep = (op_r == OP_PROGRAM) ? 3'h3 : 3'h5;
    stepAddr = UNLOCK_A1;
    stepData = cmdWord(CODE_UNLOCK1);
    case (step_r)
      3'h0: stepData = cmdWord(CODE_UNLOCK1);
      3'h1:
      begin
        stepAddr = UNLOCK_A2;
        stepData = cmdWord(CODE_UNLOCK2);
      end
      3'h2: stepData = cmdWord((op_r == OP_PROGRAM) ? CODE_PROGRAM : CODE_ERASE);
      3'h3:
      begin
        if (op_r == OP_PROGRAM)
        begin
          stepAddr = addr_r;
          stepData = data_r;
        end
        else
          stepData = cmdWord(CODE_UNLOCK1);
      end
      3'h4:
      begin
        stepAddr = UNLOCK_A2;
        stepData = cmdWord(CODE_UNLOCK2);
      end
      default:
      begin
        if (op_r == OP_SECTOR)
        begin
          stepAddr = alignAddr(addr_r, SECTOR_LSB);
          stepData = cmdWord(CODE_SECTOR);
        end
        else if (op_r == OP_BLOCK)
        begin
          stepAddr = alignAddr(addr_r, BLOCK_LSB);
          stepData = cmdWord(CODE_BLOCK);
        end
        else
          stepData = cmdWord(CODE_CHIP);
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r      <= ST_IDLE;
      op_r         <= OP_READ;
      addr_r       <= '0;
      data_r       <= '0;
      step_r       <= '0;
      prevStatus_r <= '0;
      reread_r     <= '0;
      wait_r       <= '0;
      busy_r       <= '0;
      firstPoll_r  <= 1'b0;
      cmdReady     <= 1'b0;
      cmdDone      <= 1'b0;
      cmdError     <= 1'b0;
      readData     <= '0;
      cyc.req      <= 1'b0;
      cyc.isWrite  <= 1'b0;
      cyc.addr     <= '0;
      cyc.wdata    <= '0;
    end
    else
    begin
      cmdDone <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          cmdReady <= 1'b1;
          if (cmdStart && cmdReady)
          begin
            cmdReady <= 1'b0;
            cmdError <= 1'b0;
            addr_r   <= cmdAddr;
            data_r   <= cmdData;
            step_r   <= '0;
            if (cmdOp > 3'(OP_CHIP))
            begin
              op_r  <= OP_READ;
              state_r <= ST_READ;
            end
            else
            begin
              op_r    <= pnce_op_t'(cmdOp);
              state_r <= (cmdOp == 3'(OP_READ)) ? ST_READ : ST_WRITE;
            end
          end
        end
        ST_WRITE:
        begin
          cyc.req     <= 1'b1;
          cyc.isWrite <= 1'b1;
          cyc.addr    <= stepAddr;
          cyc.wdata   <= stepData;
          if (cyc.done)
          begin
            cyc.req <= 1'b0;
            if (step_r == lastStep)
            begin
              // No new command until status says idle, or until a program poll times out
              busy_r      <= '0;
              reread_r    <= '0;
              firstPoll_r <= 1'b1;
              state_r     <= ST_POLL;
            end
            else
              step_r <= step_r + 3'h1;
          end
        end
        ST_POLL:
        begin
          busy_r      <= busy_r + 32'h1;
          cyc.req     <= 1'b1;
          cyc.isWrite <= 1'b0;
          cyc.addr    <= addr_r;
          if (cyc.done)
          begin
            cyc.req <= 1'b0;
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          busy_r       <= busy_r + 32'h1;
          prevStatus_r <= cyc.rdata;
          firstPoll_r  <= 1'b0;
          // Toggle bit stops and poll bit reads final value when finished
          if (!firstPoll_r
              && (cyc.rdata[TOGGLE_BIT] == prevStatus_r[TOGGLE_BIT])
              && (cyc.rdata[POLL_BIT] == ((op_r == OP_PROGRAM) ? data_r[POLL_BIT]
                                                                : 1'b1)))
          begin
            // A read racing completion is trusted only after two clean rereads
            if (reread_r == 2'h2)
            begin
              wait_r  <= CNT_W'(SETTLE_CY);
              state_r <= ST_WAIT;
            end
            else
            begin
              reread_r <= reread_r + 2'h1;
              state_r  <= ST_POLL;
            end
          end
          else
          begin
            reread_r <= '0;
            if (op_r == OP_PROGRAM && busy_r >= 32'(PROG_TIMEOUT_CY))
            begin
              cmdError <= 1'b1;
              state_r  <= ST_END;
            end
            else
              state_r <= ST_POLL;
          end
        end
        ST_WAIT:
        begin
          if (wait_r > CNT_W'(1))
            wait_r <= wait_r - CNT_W'(1);
          else
            state_r <= ST_READ;
        end
        ST_READ:
        begin
          cyc.req     <= 1'b1;
          cyc.isWrite <= 1'b0;
          cyc.addr    <= addr_r;
          if (cyc.done)
          begin
            cyc.req  <= 1'b0;
            readData <= cyc.rdata;
            if (op_r == OP_PROGRAM && cyc.rdata != data_r)
              cmdError <= 1'b1;
            state_r <= ST_END;
          end
        end
        default:
        begin
          cmdDone <= 1'b1;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : pnce_host

// [pnce_host_props.sv]
// Pin and handshake checker for the NOR command host.
// Assumes it is bound to pnce_host and sees only its ports.
`timescale 1ns/100ps
module pnce_host_props
  import pnce_pkg::*;
#(
  parameter int PROG_TIMEOUT_CY = PROG_CY
)
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              cmdStart,
  input wire logic [2:0]        cmdOp,
  input wire logic [ADDR_W-1:0] cmdAddr,
  input wire logic [DATA_W-1:0] cmdData,
  input wire logic              cmdReady,
  input wire logic              cmdDone,
  input wire logic              cmdError,
  input wire logic [DATA_W-1:0] readData,
  input wire logic [DATA_W-1:0] flashDqIn,
  input wire logic [DATA_W-1:0] flashDqOut,
  input wire logic              flashDqOe,
  input wire logic [ADDR_W-1:0] flashAddr,
  input wire logic              chipSelect_n,
  input wire logic              outputGate_n,
  input wire logic              writeStrobe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_writeSel; !writeStrobe_n |-> !chipSelect_n; endproperty
  a_writeSel: assert property (p_writeSel) else $error("strobe low without select");
  property p_inhibit; !writeStrobe_n |-> outputGate_n && flashDqOe; endproperty
  a_inhibit: assert property (p_inhibit) else $error("write with gate low");
  property p_noFight; !outputGate_n |-> !flashDqOe && writeStrobe_n; endproperty
  a_noFight: assert property (p_noFight) else $error("host drives during read");
  property p_width; $fell(writeStrobe_n) |-> !writeStrobe_n [*5]; endproperty
  a_width: assert property (p_width) else $error("write strobe too short");
  property p_hold;
    !writeStrobe_n && $past(writeStrobe_n) == 1'b0 |-> $stable(flashAddr) && $stable(flashDqOut);
  endproperty
  a_hold: assert property (p_hold) else $error("address or data moved in write");
  property p_selAfter; $rose(writeStrobe_n) |-> !chipSelect_n ##1 chipSelect_n; endproperty
  a_selAfter: assert property (p_selAfter) else $error("select not outliving strobe");
  property p_readGate;
    $fell(outputGate_n) |-> (!outputGate_n && !chipSelect_n) [*7];
  endproperty
  a_readGate: assert property (p_readGate) else $error("read gate too short");
  property p_idle; cmdReady |-> chipSelect_n && writeStrobe_n; endproperty
  a_idle: assert property (p_idle) else $error("bus busy while ready");
  property p_taken; cmdStart && cmdReady |=> !cmdReady; endproperty
  a_taken: assert property (p_taken) else $error("ready stayed after start");
endmodule : pnce_host_props

bind pnce_host pnce_host_props #(.PROG_TIMEOUT_CY(PROG_TIMEOUT_CY)) u_props (.*);

// [pnce_flash_model.sv]
// Behavioural x16 NOR flash facing the host controller pins.
// Assumes host strobes move on rising clk; model samples on falling clk.
`timescale 1ns/100ps
module pnce_flash_model
  import pnce_pkg::*;
#(
  parameter int PROG_BUSY_CY  = 100,
  parameter int ERASE_BUSY_CY = 150
)
(
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire logic              chipSelect_n,
  input  wire logic              outputGate_n,
  input  wire logic              writeStrobe_n,
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire logic [DATA_W-1:0] flashDqOut,
  output logic      [DATA_W-1:0] devDq
);
  logic [DATA_W-1:0] mem [int];
  logic [ADDR_W-1:0] addrLat;
  logic [DATA_W-1:0] dataLat, progData, cur;
  logic [DATA_W-1:0] lastOut = '0;
  logic              wsPrev = 1'b1, ogPrev = 1'b1, toggle = 1'b0, isProg = 1'b0;
  int                step = 0, busy = 0, settle = 0;

  function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction : rd

  task automatic command(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int   sh;
    logic hit;
    hit = (d == CODE_CHIP && a == UNLOCK_A1) || d == CODE_SECTOR || d == CODE_BLOCK;
    sh = (d == CODE_SECTOR) ? SECTOR_LSB : (d == CODE_BLOCK) ? BLOCK_LSB : 31;
    // Upper data byte never reaches the decoder
    case (step)
      0, 3: step <= (a == UNLOCK_A1 && d == CODE_UNLOCK1) ? step + 1 : 0;
      1, 4: step <= (a == UNLOCK_A2 && d == CODE_UNLOCK2) ? step + 1 : 0;
      2: step <= (a != UNLOCK_A1) ? 0 : (d == CODE_PROGRAM) ? 6 : (d == CODE_ERASE) ? 3 : 0;
      5:
      begin
        step <= 0;
        if (hit)
        begin
          foreach (mem[k])
            if ((k >> sh) == (int'(a) >> sh))
              mem[k] = 16'hffff;
          busy <= ERASE_BUSY_CY;
          isProg <= 1'b0;
        end
      end
      default:
      begin
        step <= 0;
        progData <= dataLat;
        isProg <= 1'b1;
        busy <= PROG_BUSY_CY;
        mem[int'(a)] = rd(a) & dataLat;
      end
    endcase
  endtask : command

  always @(negedge clk)
  begin
    wsPrev <= writeStrobe_n;
    ogPrev <= outputGate_n;
    if (busy > 0 && !stall)
      busy <= busy - 1;
    settle <= (busy == 1 && !stall) ? SETTLE_CY : (settle > 0 ? settle - 1 : 0);
    if (wsPrev && !writeStrobe_n && !chipSelect_n)
      addrLat <= flashAddr;
    if (!writeStrobe_n && !chipSelect_n)
      dataLat <= flashDqOut;
    if (!ogPrev && outputGate_n && busy > 0)
      toggle <= !toggle;
    if (!chipSelect_n && !outputGate_n)
      lastOut <= devDq;
    // Busy part drops every write, mode exit included
    if (!wsPrev && writeStrobe_n && !chipSelect_n && outputGate_n && busy == 0)
      command(addrLat, dataLat[7:0]);
  end

  always @*
  begin
    cur = rd(flashAddr);
    if (chipSelect_n || outputGate_n)
      devDq = ~lastOut;
    else if (busy > 0)
      devDq = isProg ? {progData[15:8], ~progData[7], toggle, progData[5:0]}
                     : {8'h00, 1'b0, toggle, 6'h00};
    else if (settle > 0)
      devDq = {~cur[15:8], cur[7:6], ~cur[5:0]};
    else
      devDq = cur;
  end
endmodule : pnce_flash_model

// [tb_pnce_host.sv]
// Self-checking bench for the NOR command host against the flash model.
// Assumes the model shares the bench clock and pins.
`timescale 1ns/100ps
module tb_pnce_host
  import pnce_pkg::*;
;
  localparam int TO_CY = 200;
  localparam int LIMIT = 40000;
  logic              clk = 1'b0, sys_rst = 1'b1, cmdStart = 1'b0, stall = 1'b0;
  logic [2:0]        cmdOp = '0;
  logic [ADDR_W-1:0] cmdAddr = '0, flashAddr;
  logic [DATA_W-1:0] cmdData = '0, flashDqIn, flashDqOut, readData, devDq;
  logic              cmdReady, cmdDone, cmdError, flashDqOe;
  logic              chipSelect_n, outputGate_n, writeStrobe_n;
  int                miscompares = 0, testsRun = 0, wrCount = 0, cycles = 0;

  always #5 clk = ~clk;
  assign flashDqIn = flashDqOe ? flashDqOut : devDq;

  pnce_host #(.PROG_TIMEOUT_CY(TO_CY)) i_dut (.*);
  pnce_flash_model i_flash (.clk(clk), .stall(stall), .chipSelect_n(chipSelect_n),
    .outputGate_n(outputGate_n), .writeStrobe_n(writeStrobe_n), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .devDq(devDq));

  always @(posedge writeStrobe_n)
    wrCount++;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      summarize();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Bounded waits keep a stuck host from hiding behind the cycle limit
  task automatic runCmd(logic [2:0] op, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, int nWr);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    wrCount = 0;
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    cmdStart = 1'b1;
    @(negedge clk);
    cmdStart = 1'b0;
    n = 0;
    while (cmdDone !== 1'b1 && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    check("cmdDone", cmdDone, 1'b1);
    check("write count", wrCount, nWr);
  endtask : runCmd

  task automatic t_reset();
    check("idle pins", {chipSelect_n, outputGate_n, writeStrobe_n, flashDqOe}, 4'he);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    check("cmdReady", cmdReady, 1'b1);
  endtask : t_reset

  task automatic t_program();
    runCmd(3'h1, 19'h01234, 16'h5a3c, 4);
    check("program low bit7", readData, 16'h5a3c);
    runCmd(3'h1, 19'h01800, 16'h80a5, 4);
    check("program high bit7", readData, 16'h80a5);
    check("program error", cmdError, 1'b0);
    runCmd(3'h0, 19'h01234, 16'h0000, 0);
    check("read back", readData, 16'h5a3c);
  endtask : t_program

  task automatic t_erase();
    runCmd(3'h2, 19'h01234, 16'h0000, 6);
    check("sector erased", readData, 16'hffff);
    runCmd(3'h0, 19'h01800, 16'h0000, 0);
    check("next sector kept", readData, 16'h80a5);
    runCmd(3'h1, 19'h08000, 16'h1357, 4);
    runCmd(3'h3, 19'h0ffff, 16'h0000, 6);
    runCmd(3'h0, 19'h08000, 16'h0000, 0);
    check("block erased", readData, 16'hffff);
    runCmd(3'h0, 19'h01800, 16'h0000, 0);
    check("other block kept", readData, 16'h80a5);
    runCmd(3'h4, 19'h01800, 16'h0000, 6);
    runCmd(3'h7, 19'h01800, 16'h0000, 0);
    check("chip erased", readData, 16'hffff);
  endtask : t_erase

  task automatic t_faults();
    runCmd(3'h1, 19'h02000, 16'h1234, 4);
    runCmd(3'h1, 19'h02000, 16'hff00, 4);
    check("overwrite error", cmdError, 1'b1);
    check("overwrite data", readData, 16'h1200);
    stall = 1'b1;
    runCmd(3'h1, 19'h03000, 16'h00ff, 4);
    check("timeout error", cmdError, 1'b1);
    stall = 1'b0;
    repeat (300) @(negedge clk);
    runCmd(3'h0, 19'h03000, 16'h0000, 0);
    check("late data", readData, 16'h00ff);
    check("error cleared", cmdError, 1'b0);
  endtask : t_faults

  initial
  begin
    repeat (10) @(negedge clk);
    t_reset();
    t_program();
    t_erase();
    t_faults();
    summarize();
  end
endmodule : tb_pnce_host
